// [include/tmw_pkg.sv]
/*
 * tmw_pkg: constants, register map and carrier types for the 8-bit timer
 * waveform output block.
 * assumes: a single 25 MHz core clock; APB slave with 32-bit data.
 */
package tmw_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] CMPA_OFS = 8'h08;
    localparam logic [7:0] CMPB_OFS = 8'h0c;
    localparam logic [7:0] FLAG_OFS = 8'h10;
    localparam logic [7:0] FORCE_OFS = 8'h14;
    localparam logic [7:0] PORT_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1c;
    // control register fields
    localparam int MODEA_POS = 6;
    localparam int MODEB_POS = 4;
    localparam int WGM_POS = 0;
    localparam int PRESC_POS = 8;
    // flag register fields
    localparam int OVF_POS = 0;
    localparam int CFA_POS = 1;
    localparam int CFB_POS = 2;
    // port register fields
    localparam int PDIRA_POS = 0;
    localparam int PDIRB_POS = 1;
    localparam int PVALA_POS = 2;
    localparam int PVALB_POS = 3;
    // counter landmarks
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hff;
    // reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic OUT_RST = 1'b0;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;

    // waveform generation modes
    typedef enum logic [2:0] {
        WGM_NORMAL = 3'h0,
        WGM_PC_FF = 3'h1,
        WGM_CTC = 3'h2,
        WGM_FAST_FF = 3'h3,
        WGM_RSV4 = 3'h4,
        WGM_PC_OCR = 3'h5,
        WGM_RSV6 = 3'h6,
        WGM_FAST_OCR = 3'h7
    } tmw_wgm_t;

    // control settings carried as one group
    typedef struct packed {
        logic [1:0] modeA;
        logic [1:0] modeB;
        tmw_wgm_t wgm;
        logic [7:0] presc;
    } tmw_ctrl_t;

    // pin-side signals of one output channel pair
    typedef struct packed {
        logic outA;
        logic outB;
        logic oeA;
        logic oeB;
    } tmw_pins_t;
endpackage

// [hw/tmw_timer.sv]
/*
 * tmw_timer: 8-bit timer counter with compare-match waveform outputs,
 * normal, clear-on-compare and fast PWM counting, and port override.
 * assumes: APB master on core_clk; port pins resolved outside from
 * pins outA/outB and oeA/oeB; timer tick from an internal divider set by software.
 */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module tmw_timer
    import tmw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output tmw_pkg::tmw_pins_t pins
);
    import tmw_pkg::*;

    tmw_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] counterValue_r, counterValue_nxt;
    logic [7:0] cmpRegA_r, cmpRegA_nxt;
    logic [7:0] cmpRegB_r, cmpRegB_nxt;
    logic [7:0] cmpBufA_r, cmpBufA_nxt;
    logic [7:0] cmpBufB_r, cmpBufB_nxt;
    logic overflowFlag_r, overflowFlag_nxt;
    logic cmpFlagA_r, cmpFlagA_nxt;
    logic cmpFlagB_r, cmpFlagB_nxt;
    logic matchA_r, matchA_nxt;
    logic matchB_r, matchB_nxt;
    logic blockMatch_r, blockMatch_nxt;
    logic outBitA_r, outBitA_nxt;
    logic outBitB_r, outBitB_nxt;
    logic [3:0] portReg_r, portReg_nxt;
    logic [7:0] prescCnt_r, prescCnt_nxt;
    logic tick_r, tick_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    tmw_pins_t pins_nxt;

    logic wrEn, rdEn, isPwm, isFast, isTopA;
    logic [7:0] topVal;
    logic atTop, hitA, hitB, forceA, forceB;

    // decoded mode and access strobes
    // accesses are taken only in the first access cycle, so the pready
    // cycle that follows never repeats a write or a read side effect
    always_comb
    begin
        wrEn = psel && penable && pwrite && !pready;
        rdEn = psel && penable && !pwrite && !pready;
        isFast = (ctrl_r.wgm == WGM_FAST_FF) || (ctrl_r.wgm == WGM_FAST_OCR);
        isPwm = ctrl_r.wgm[0];
        isTopA = (ctrl_r.wgm == WGM_CTC) || (ctrl_r.wgm == WGM_FAST_OCR);
        topVal = isTopA ? cmpRegA_r : MAX_VAL;
        atTop = (counterValue_r == topVal);
        hitA = (counterValue_r == cmpRegA_r) && !blockMatch_r;
        hitB = (counterValue_r == cmpRegB_r) && !blockMatch_r;
        forceA = wrEn && (paddr == FORCE_OFS) && pwdata[0] && !isPwm;
        forceB = wrEn && (paddr == FORCE_OFS) && pwdata[1] && !isPwm;
    end

    // output action per channel; mode read live so new mode hits next match
    // phase-correct and reserved modes fall through to the non-fast branch,
    // so their outputs only move on matches or forced compares
    function automatic logic nextOut(input logic cur, input logic [1:0] mode,
                                     input logic fast, input logic topSel,
                                     input logic isA, input logic match,
                                     input logic bottom, input logic frc,
                                     input logic extreme);
        logic res;
        res = cur;
        if (mode == 2'h0)
        begin
            res = cur;
        end
        else if (!fast)
        begin
            if (match || frc)
            begin
                unique case (mode)
                    2'h1: res = !cur;
                    2'h2: res = 1'b0;
                    default: res = 1'b1;
                endcase
            end
        end
        else if (mode == 2'h1)
        begin
            if (isA && topSel && match)
            begin
                res = !cur;
            end
        end
        else
        begin
            // match ignored when compare equals top; end action alone decides
            if (bottom)
            begin
                res = !mode[0];
            end
            else if (match && !extreme)
            begin
                res = mode[0];
            end
        end
        return res;
    endfunction

    // counter, flags, compare buffers and outputs
    // order of the blocks below sets priority: tick first, then force,
    // then software writes, so a counter write overrides the count step
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        counterValue_nxt = counterValue_r;
        cmpRegA_nxt = cmpRegA_r;
        cmpRegB_nxt = cmpRegB_r;
        cmpBufA_nxt = cmpBufA_r;
        cmpBufB_nxt = cmpBufB_r;
        overflowFlag_nxt = overflowFlag_r;
        cmpFlagA_nxt = cmpFlagA_r;
        cmpFlagB_nxt = cmpFlagB_r;
        matchA_nxt = matchA_r;
        matchB_nxt = matchB_r;
        blockMatch_nxt = blockMatch_r;
        outBitA_nxt = outBitA_r;
        outBitB_nxt = outBitB_r;
        portReg_nxt = portReg_r;
        prescCnt_nxt = prescCnt_r;
        tick_nxt = 1'b0;
        // tick divider: one pulse every presc+1 clocks
        if (prescCnt_r >= ctrl_r.presc)
        begin
            prescCnt_nxt = 8'h00;
            tick_nxt = 1'b1;
        end
        else
        begin
            prescCnt_nxt = prescCnt_r + 8'h01;
        end
        if (tick_r)
        begin
            matchA_nxt = hitA;
            matchB_nxt = hitB;
            blockMatch_nxt = 1'b0;
            // flags set one tick after the match
            if (matchA_r)
            begin
                cmpFlagA_nxt = 1'b1;
            end
            if (matchB_r)
            begin
                cmpFlagB_nxt = 1'b1;
            end
            // counting sequence follows waveform mode only
            if (ctrl_r.wgm == WGM_CTC && hitA)
            begin
                counterValue_nxt = BOTTOM_VAL;
            end
            else if (isFast && atTop)
            begin
                counterValue_nxt = BOTTOM_VAL;
            end
            else
            begin
                counterValue_nxt = counterValue_r + 8'h01;
            end
            if (counterValue_r == MAX_VAL && !isFast)
            begin
                overflowFlag_nxt = 1'b1;
            end
            if (isFast && atTop)
            begin
                overflowFlag_nxt = 1'b1;
                cmpRegA_nxt = cmpBufA_r;
                cmpRegB_nxt = cmpBufB_r;
            end
            outBitA_nxt = nextOut(outBitA_r, ctrl_r.modeA, isFast, ctrl_r.wgm[2], 1'b1,
                                  hitA, isFast && atTop, 1'b0, cmpRegA_r == topVal);
            outBitB_nxt = nextOut(outBitB_r, ctrl_r.modeB, isFast, ctrl_r.wgm[2], 1'b0,
                                  hitB, isFast && atTop, 1'b0, cmpRegB_r == topVal);
        end
        // forced compare: output only, no flag, no counter clear
        if (forceA)
        begin
            outBitA_nxt = nextOut(outBitA_r, ctrl_r.modeA, 1'b0, 1'b0, 1'b1,
                                  1'b0, 1'b0, 1'b1, 1'b0);
        end
        if (forceB)
        begin
            outBitB_nxt = nextOut(outBitB_r, ctrl_r.modeB, 1'b0, 1'b0, 1'b0,
                                  1'b0, 1'b0, 1'b1, 1'b0);
        end
        // software writes; counter write wins and blocks the next match
        if (wrEn)
        begin
            unique case (paddr)
                CTRL_OFS:
                begin
                    ctrl_nxt.modeA = pwdata[MODEA_POS +: 2];
                    ctrl_nxt.modeB = pwdata[MODEB_POS +: 2];
                    ctrl_nxt.wgm = tmw_wgm_t'(pwdata[WGM_POS +: 3]);
                    ctrl_nxt.presc = pwdata[PRESC_POS +: 8];
                end
                COUNT_OFS:
                begin
                    counterValue_nxt = pwdata[7:0];
                    blockMatch_nxt = 1'b1;
                end
                CMPA_OFS:
                begin
                    cmpBufA_nxt = pwdata[7:0];
                    if (!isPwm)
                    begin
                        cmpRegA_nxt = pwdata[7:0];
                    end
                end
                CMPB_OFS:
                begin
                    cmpBufB_nxt = pwdata[7:0];
                    if (!isPwm)
                    begin
                        cmpRegB_nxt = pwdata[7:0];
                    end
                end
                FLAG_OFS:
                begin
                    // write one clears, but a same-cycle set wins
                    if (pwdata[OVF_POS] && !overflowFlag_nxt)
                    begin
                        overflowFlag_nxt = 1'b0;
                    end
                    else if (pwdata[OVF_POS] && !(overflowFlag_nxt && !overflowFlag_r))
                    begin
                        overflowFlag_nxt = 1'b0;
                    end
                    if (pwdata[CFA_POS] && !(cmpFlagA_nxt && !cmpFlagA_r))
                    begin
                        cmpFlagA_nxt = 1'b0;
                    end
                    if (pwdata[CFB_POS] && !(cmpFlagB_nxt && !cmpFlagB_r))
                    begin
                        cmpFlagB_nxt = 1'b0;
                    end
                end
                PORT_OFS:
                begin
                    portReg_nxt = pwdata[3:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    // pin override and APB answer
    // pins are built from next values so they change on the same edge as
    // the state behind them, keeping the output a plain flip-flop
    // unmapped reads return zero data together with the error flag
    always_comb
    begin
        pins_nxt.outA = (ctrl_nxt.modeA != 2'h0) ? outBitA_nxt : portReg_nxt[PVALA_POS];
        pins_nxt.outB = (ctrl_nxt.modeB != 2'h0) ? outBitB_nxt : portReg_nxt[PVALB_POS];
        pins_nxt.oeA = portReg_nxt[PDIRA_POS];
        pins_nxt.oeB = portReg_nxt[PDIRB_POS];
        pready_nxt = (rdEn || wrEn);
        pslverr_nxt = 1'b0;
        prdata_nxt = ERR_DATA;
        if (rdEn)
        begin
            unique case (paddr)
                CTRL_OFS: prdata_nxt = {16'h0000, ctrl_r.presc, ctrl_r.modeA, ctrl_r.modeB,
                                        1'b0, ctrl_r.wgm};
                COUNT_OFS: prdata_nxt = {24'h000000, counterValue_r};
                CMPA_OFS: prdata_nxt = {24'h000000, cmpBufA_r};
                CMPB_OFS: prdata_nxt = {24'h000000, cmpBufB_r};
                FLAG_OFS: prdata_nxt = {29'h0, cmpFlagB_r, cmpFlagA_r, overflowFlag_r};
                FORCE_OFS: prdata_nxt = ERR_DATA;
                PORT_OFS: prdata_nxt = {28'h0, portReg_r};
                STAT_OFS: prdata_nxt = {30'h0, outBitB_r, outBitA_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        else if (wrEn)
        begin
            pslverr_nxt = (paddr > STAT_OFS) || (paddr[1:0] != 2'h0) || (paddr == STAT_OFS);
        end
    end

    // state registers
    // reset branch loads constants only
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= '{modeA: 2'h0, modeB: 2'h0, wgm: WGM_NORMAL, presc: PRESC_RST};
            counterValue_r <= COUNT_RST;
            cmpRegA_r <= CMP_RST;
            cmpRegB_r <= CMP_RST;
            cmpBufA_r <= CMP_RST;
            cmpBufB_r <= CMP_RST;
            overflowFlag_r <= 1'b0;
            cmpFlagA_r <= 1'b0;
            cmpFlagB_r <= 1'b0;
            matchA_r <= 1'b0;
            matchB_r <= 1'b0;
            blockMatch_r <= 1'b0;
            outBitA_r <= OUT_RST;
            outBitB_r <= OUT_RST;
            portReg_r <= 4'h0;
            prescCnt_r <= 8'h00;
            tick_r <= 1'b0;
            prdata <= ERR_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pins <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            counterValue_r <= counterValue_nxt;
            cmpRegA_r <= cmpRegA_nxt;
            cmpRegB_r <= cmpRegB_nxt;
            cmpBufA_r <= cmpBufA_nxt;
            cmpBufB_r <= cmpBufB_nxt;
            overflowFlag_r <= overflowFlag_nxt;
            cmpFlagA_r <= cmpFlagA_nxt;
            cmpFlagB_r <= cmpFlagB_nxt;
            matchA_r <= matchA_nxt;
            matchB_r <= matchB_nxt;
            blockMatch_r <= blockMatch_nxt;
            outBitA_r <= outBitA_nxt;
            outBitB_r <= outBitB_nxt;
            portReg_r <= portReg_nxt;
            prescCnt_r <= prescCnt_nxt;
            tick_r <= tick_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            pins <= pins_nxt;
        end
    end
endmodule

// [verification/tmw_timer_checker.sv]
/* tmw_timer_checker: port-level assertions for the timer waveform block.
   assumes: bound to tmw_timer; one clock, async active-high reset. */
`timescale 1ns/1ps
module tmw_timer_checker
    import tmw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tmw_pkg::tmw_pins_t pins
);
    logic [7:0] ctrlT_r;
    logic [3:0] portT_r;
    logic [7:0] cmpaT_r;
    logic [9:0] stab_r;
    logic wrDone;
    // a write that the slave accepted
    assign wrDone = psel && penable && pready && pwrite && !pslverr;
    // shadow of settings plus cycles since the last setup write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrlT_r <= 8'h00;
            portT_r <= 4'h0;
            cmpaT_r <= 8'h00;
            stab_r <= 10'h000;
        end
        else
        begin
            if (wrDone && paddr == CTRL_OFS) ctrlT_r <= pwdata[7:0];
            if (wrDone && paddr == PORT_OFS) portT_r <= pwdata[3:0];
            if (wrDone && paddr == CMPA_OFS) cmpaT_r <= pwdata[7:0];
            if (wrDone && (paddr == CTRL_OFS || paddr == CMPA_OFS)) stab_r <= 10'h000;
            else if (stab_r != 10'h3ff) stab_r <= stab_r + 10'h001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($fell(rst) |-> pins == 4'h0)
        else $error("pins not clear after reset");
    dir_follow_a: assert property (!pready |-> pins.oeA == portT_r[PDIRA_POS]
        && pins.oeB == portT_r[PDIRB_POS]) else $error("pin enable not from direction bit");
    port_value_a: assert property (!pready && ctrlT_r[MODEA_POS+:2] == 2'h0
        |-> pins.outA == portT_r[PVALA_POS]) else $error("port value not on pin");
    force_action_a: assert property (wrDone && paddr == FORCE_OFS && pwdata[0]
        && ctrlT_r[MODEA_POS+1] && !ctrlT_r[WGM_POS] |=> pins.outA == ctrlT_r[MODEA_POS])
        else $error("force action missing");
    flat_level_a: assert property (ctrlT_r == 8'h83 && cmpaT_r == MAX_VAL
        && stab_r >= 10'd600 |-> pins.outA) else $error("output not constant");
    ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside ready cycle");
    unmapped_err_a: assert property (pready && paddr > STAT_OFS |-> pslverr)
        else $error("unmapped address not refused");
endmodule
bind tmw_timer tmw_timer_checker u_tmw_timer_checker (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));

// [verification/tmw_pin_model.sv]
/* tmw_pin_model: port pin logic at the far side of the compare outputs.
   assumes: pins from tmw_timer; no pull on the pads. */
`timescale 1ns/1ps
module tmw_pin_model
    import tmw_pkg::*;
(
    input wire logic core_clk,
    input wire tmw_pkg::tmw_pins_t pins,
    output logic padA,
    output logic padB
);
    logic float_r = 1'b0;
    // undriven pads wander so a stale level never reads as valid
    always_ff @(posedge core_clk) float_r <= !float_r;
    // pad shows the output only while direction is output
    assign padA = pins.oeA ? pins.outA : float_r;
    assign padB = pins.oeB ? pins.outB : float_r;
endmodule

// [verification/tmw_timer_test.sv]
/* tmw_timer_test: self-checking bench for tmw_timer over APB.
   assumes: 25 MHz core_clk, divider left at zero (tick every clock). */
`timescale 1ns/1ps
module tmw_timer_test;
    import tmw_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} tmw_rrow_t;
    typedef struct {logic [7:0] ctl; logic [7:0] ca; logic [7:0] cb; logic ch; int per;} tmw_wrow_t;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, er, padA, padB;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    tmw_pins_t pins;
    int error_cnt, cmp_count, p;
    tmw_rrow_t rrows[7] = '{'{CTRL_OFS, 32'h0, 1'b0}, '{CMPA_OFS, 32'h0, 1'b0},
        '{CMPB_OFS, 32'h0, 1'b0}, '{PORT_OFS, 32'h0, 1'b0}, '{STAT_OFS, 32'h0, 1'b0},
        '{FORCE_OFS, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1}};
    tmw_wrow_t wrows[6] = '{'{8'h42, 8'h00, 8'h00, 1'b0, 2}, '{8'h42, 8'h04, 8'h00, 1'b0, 10},
        '{8'h83, 8'h40, 8'h00, 1'b0, 256}, '{8'hc3, 8'h40, 8'h00, 1'b0, 256},
        '{8'h47, 8'h04, 8'h00, 1'b0, 10}, '{8'h27, 8'h09, 8'h02, 1'b1, 10}};
    tmw_timer u_tmw_timer (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins));
    tmw_pin_model u_tmw_pin_model (.core_clk(core_clk), .pins(pins), .padA(padA), .padB(padB));
    // free-running core clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one APB transfer, held until ready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            final_report();
        end
    endtask
    // cycles between the 2nd and 3rd rising edge of one output
    task per(input logic ch, output int q);
        int k, n;
        logic pv, cv;
        k = 0;
        n = 0;
        q = 0;
        pv = ch ? pins.outB : pins.outA;
        while (n < 3 && k < 2000)
        begin
            @(posedge core_clk);
            #1;
            cv = ch ? pins.outB : pins.outA;
            k++;
            q++;
            if (cv === 1'b1 && pv === 1'b0) n++;
            if (cv === 1'b1 && pv === 1'b0 && n == 2) q = 0;
            pv = cv;
        end
        if (k >= 2000)
        begin
            error_cnt++;
            final_report();
        end
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // register defaults and the unmapped hole
        foreach (rrows[i])
        begin
            apb(1'b0, rrows[i].a, 32'h0);
            chk(rd, rrows[i].d);
            chk({31'h0, er}, {31'h0, rrows[i].e});
        end
        $display("test reset values done");
        // waveform periods for clear-on-compare and both fast PWM counting modes, output modes 1 to 3
        foreach (wrows[i])
        begin
            apb(1'b1, CMPA_OFS, {24'h0, wrows[i].ca});
            apb(1'b1, CMPB_OFS, {24'h0, wrows[i].cb});
            apb(1'b1, CTRL_OFS, {24'h0, wrows[i].ctl});
            per(wrows[i].ch, p);
            chk(32'(p), 32'(wrows[i].per));
        end
        $display("test waveform periods done");
        // force sets the bit with the pin driver off, mode zero keeps it
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, PORT_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'hc0);
        apb(1'b1, FORCE_OFS, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (300) @(posedge core_clk);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, PORT_OFS, 32'h1);
        @(negedge core_clk);
        chk({31'h0, padA}, 32'h0);
        apb(1'b1, CTRL_OFS, 32'hc0);
        @(negedge core_clk);
        chk({31'h0, padA}, 32'h1);
        $display("test port override done");
        // normal mode wrap sets overflow, mid-count does not
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, COUNT_OFS, 32'h10);
        apb(1'b1, FLAG_OFS, 32'h7);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        apb(1'b1, COUNT_OFS, 32'hfd);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        // clear-on-compare never reaches max, compare flag set
        apb(1'b1, CMPA_OFS, 32'h20);
        apb(1'b1, CTRL_OFS, 32'h02);
        apb(1'b1, COUNT_OFS, 32'h0);
        apb(1'b1, FLAG_OFS, 32'h7);
        repeat (300) @(posedge core_clk);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(rd & 32'h3, 32'h2);
        $display("test flags done");
        // compare at max gives a flat output
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, CMPA_OFS, 32'hff);
        apb(1'b1, CTRL_OFS, 32'h83);
        repeat (700) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pins.outA}, 32'h1);
        $display("test flat level done");
        // reset in mid-run clears the compare output bits and pins
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({28'h0, pins}, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
